// file: logic/cmpsr_top.sv
// cmpsr_top: digital control for three comparators plus the set/reset latch, apb slave.
// assumes raw comparator and pin levels are asynchronous; direction bits come from the
// port logic on the same clock; pin pads resolve value and enable outside.
//
// Overview of operation
// - enable bit powers each comparator on or off
// - result is one when plus exceeds minus
// - invert bit flips result before every consumer
// - pin driven when pin-enable set, direction clear
// - speed select resets to one, normal power
// - hysteresis enable bit per comparator
// - sync mode updates timer result on falling edge
// - unimplemented register bits read as zero
// - rising edge sets flag when enabled
// - falling edge sets flag when enabled
// - plus select: pin, converter, fixed, ground
// - minus select picks one of four pins
// - mirror register shows all three results
// - latch has five set/reset source kinds
// - latch follows combined inputs, active high
// - reset dominates when set and reset both
// - software pulse bits clear themselves
// - divider select and clock set/reset enables
// - separate true and complement output enables
// - edge during flag clear leaves flag set
// - result registered every cycle
// - pulse every 4 to 512 cycles
// - per-source set and reset enable bits
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`default_nettype none
`include "cmpsr_consts.svh"

module cmpsr_top (
  input  wire logic        clock,        // system clock, 200 MHz
  input  wire logic        sys_rst,      // async reset, active high
  input  wire logic [7:0]  paddr,        // apb byte address
  input  wire logic        psel,         // apb select
  input  wire logic        penable,      // apb access phase
  input  wire logic        pwrite,       // apb direction, 1 = write
  input  wire logic [31:0] pwdata,       // apb write data
  input  wire logic [3:0]  pstrb,        // apb byte strobes, lane 0 used
  output var  logic [31:0] prdata,       // apb read data
  output var  logic        pready,       // apb ready
  output var  logic        pslverr,      // apb error on unmapped address
  input  wire logic [2:0]  cmpRaw,       // raw analog results, 1 = plus above minus
  output logic      [2:0]  cmpOn,        // comparator power enables
  output logic      [2:0]  cmpFast,      // 1 = normal power, higher speed
  output logic      [2:0]  cmpHyst,      // hysteresis enables
  output logic      [5:0]  plusSel,      // plus input selects, 2 bits per comparator
  output logic      [5:0]  minusSel,     // minus input selects, 2 bits per comparator
  input  wire logic        gateTimerClk, // gate timer clock source, asynchronous
  output var  logic [2:0]  timerResult,  // results toward the gate timer and latch
  input  wire logic [2:0]  resultPinDir, // pin direction bits, 1 = input
  output logic      [2:0]  resultPinOut, // result pin values
  output var  logic [2:0]  resultPinOe,  // result pin drive enables
  input  wire logic        latchExtPin,  // external latch input, asynchronous
  input  wire logic        latchQDir,    // true output pin direction, 1 = input
  input  wire logic        latchQnDir,   // complement output pin direction, 1 = input
  output var  logic        latchQOut,    // latch true output
  output var  logic        latchQOe,     // latch true pin drive enable
  output var  logic        latchQnOut,   // latch complement output
  output var  logic        latchQnOe     // latch complement pin drive enable
);

  ////////////////////////////////////////////////////////////////////////////////////////
  // register state

  logic [2:0]              onQ;
  logic [2:0]              pinEnQ;
  logic [2:0]              invQ;
  logic [2:0]              speedQ;
  logic [2:0]              hysQ;
  logic [2:0]              syncModeQ;
  logic [2:0]              riseEnQ;
  logic [2:0]              fallEnQ;
  cmpsr_pkg::cmpsr_plus_t  plusQ [3];
  cmpsr_pkg::cmpsr_sel_t   minusQ [3];
  logic [2:0]              resultQ;
  logic [2:0]              prevResultQ;
  logic [2:0]              flagQ;
  logic                    latchEnQ;
  logic [2:0]              divSelQ;
  logic                    qEnQ;
  logic                    qnEnQ;
  logic                    softSetQ;
  logic                    softRstQ;
  cmpsr_pkg::cmpsr_byte_t  srcEnQ;

  logic [2:0]              cmpS;
  logic                    extS;
  logic                    tmrClkS;
  logic                    tmrClkPrevQ;
  logic                    tmrFall;
  logic                    divPulse;
  logic                    wrEn;
  logic                    rdSetup;
  logic [2:0]              wrCtl0;
  logic [2:0]              wrCtl1;
  logic                    wrLatch0;
  logic                    wrLatch1;
  logic                    wrFlags;
  logic                    setIn;
  logic                    rstIn;
  logic                    latchNext;
  cmpsr_pkg::cmpsr_byte_t  rdByte;
  logic                    rdHit;

  ////////////////////////////////////////////////////////////////////////////////////////
  // input synchronisers and dividers

  cmpsr_sync #(
    .WIDTH (5)
  ) u_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .din     ({gateTimerClk, latchExtPin, cmpRaw}),
    .dout    ({tmrClkS, extS, cmpS})
  );

  cmpsr_pulse_div u_div (
    .clock   (clock),
    .sys_rst (sys_rst),
    .sel     (divSelQ),
    .pulse   (divPulse)
  );

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tmrClkPrevQ <= 1'b0;
    end else begin
      tmrClkPrevQ <= tmrClkS;
    end
  end

  assign tmrFall = tmrClkPrevQ & ~tmrClkS;

  ////////////////////////////////////////////////////////////////////////////////////////
  // apb slave: one setup and one access cycle, read data captured during setup

  assign wrEn    = psel & penable & pready & pwrite & pstrb[0];
  assign rdSetup = psel & ~penable;
  assign wrLatch0 = wrEn & (paddr == `CMPSR_OFF_LATCH0);
  assign wrLatch1 = wrEn & (paddr == `CMPSR_OFF_LATCH1);
  assign wrFlags  = wrEn & (paddr == `CMPSR_OFF_FLAGS);

  always_comb begin
    rdByte = 8'h00;
    rdHit  = 1'b0;
    for (int k = 0; k < 3; k++) begin
      if (paddr == 8'(`CMPSR_OFF_CTRL0_BASE + `CMPSR_CH_STRIDE * k)) begin
        rdHit  = 1'b1;
        rdByte = {onQ[k], resultQ[k], pinEnQ[k], invQ[k], 1'b0,
                  speedQ[k], hysQ[k], syncModeQ[k]};
      end
      if (paddr == 8'(`CMPSR_OFF_CTRL1_BASE + `CMPSR_CH_STRIDE * k)) begin
        rdHit  = 1'b1;
        rdByte = {riseEnQ[k], fallEnQ[k], plusQ[k], 2'b00, minusQ[k]};
      end
    end
    unique case (paddr)
      `CMPSR_OFF_MIRROR: begin
        rdHit  = 1'b1;
        rdByte = {5'h00, resultQ};
      end
      `CMPSR_OFF_LATCH0: begin
        rdHit  = 1'b1;
        rdByte = {latchEnQ, divSelQ, qEnQ, qnEnQ, 2'b00};        // pulse bits read zero
      end
      `CMPSR_OFF_LATCH1: begin
        rdHit  = 1'b1;
        rdByte = srcEnQ;
      end
      `CMPSR_OFF_FLAGS: begin
        rdHit  = 1'b1;
        rdByte = {5'h00, flagQ};
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= rdSetup;
      pslverr <= rdSetup & ~rdHit;
      if (rdSetup) begin
        prdata <= {24'h00_0000, rdByte};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // per comparator control, result, edge flags and pin path

  for (genvar i = 0; i < 3; i++) begin : g_cmp
    logic rawOn;
    logic riseEv;
    logic fallEv;

    assign wrCtl0[i] = wrEn & (paddr == 8'(`CMPSR_OFF_CTRL0_BASE + `CMPSR_CH_STRIDE * i));
    assign wrCtl1[i] = wrEn & (paddr == 8'(`CMPSR_OFF_CTRL1_BASE + `CMPSR_CH_STRIDE * i));

    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        onQ[i]       <= 1'(`CMPSR_CTRL0_RST >> `CMPSR_C0_ON);
        pinEnQ[i]    <= 1'(`CMPSR_CTRL0_RST >> `CMPSR_C0_PINEN);
        invQ[i]      <= 1'(`CMPSR_CTRL0_RST >> `CMPSR_C0_INV);
        speedQ[i]    <= 1'(`CMPSR_CTRL0_RST >> `CMPSR_C0_SPEED);
        hysQ[i]      <= 1'(`CMPSR_CTRL0_RST >> `CMPSR_C0_HYS);
        syncModeQ[i] <= 1'(`CMPSR_CTRL0_RST >> `CMPSR_C0_SYNC);
      end else if (wrCtl0[i]) begin
        onQ[i]       <= pwdata[`CMPSR_C0_ON];
        pinEnQ[i]    <= pwdata[`CMPSR_C0_PINEN];
        invQ[i]      <= pwdata[`CMPSR_C0_INV];
        speedQ[i]    <= pwdata[`CMPSR_C0_SPEED];
        hysQ[i]      <= pwdata[`CMPSR_C0_HYS];
        syncModeQ[i] <= pwdata[`CMPSR_C0_SYNC];
      end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        riseEnQ[i] <= 1'(`CMPSR_CTRL1_RST >> `CMPSR_C1_RISE);
        fallEnQ[i] <= 1'(`CMPSR_CTRL1_RST >> `CMPSR_C1_FALL);
        plusQ[i]   <= cmpsr_pkg::CMPSR_PLUS_PIN;
        minusQ[i]  <= 2'h0;
      end else if (wrCtl1[i]) begin
        riseEnQ[i] <= pwdata[`CMPSR_C1_RISE];
        fallEnQ[i] <= pwdata[`CMPSR_C1_FALL];
        plusQ[i]   <= cmpsr_pkg::cmpsr_plus_t'(pwdata[`CMPSR_C1_PLUS_HI:`CMPSR_C1_PLUS_LO]);
        minusQ[i]  <= pwdata[`CMPSR_C1_MINUS_HI:`CMPSR_C1_MINUS_LO];
      end
    end

    assign cmpOn[i]           = onQ[i];
    assign cmpFast[i]         = speedQ[i];
    assign cmpHyst[i]         = hysQ[i];
    assign plusSel[2*i +: 2]  = plusQ[i];
    assign minusSel[2*i +: 2] = minusQ[i];

    // a powered-down core gives no valid level, so it reads as a low comparison
    assign rawOn = cmpS[i] & onQ[i];

    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        resultQ[i]     <= 1'b0;
        prevResultQ[i] <= 1'b0;
      end else begin
        resultQ[i]     <= rawOn ^ invQ[i];
        prevResultQ[i] <= resultQ[i];
      end
    end

    assign riseEv = resultQ[i] & ~prevResultQ[i];
    assign fallEv = ~resultQ[i] & prevResultQ[i];

    // write one to clear; a new edge in the same cycle keeps the flag
    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        flagQ[i] <= 1'b0;
      end else begin
        flagQ[i] <= (riseEv & riseEnQ[i])
                  | (fallEv & fallEnQ[i])
                  | (flagQ[i] & ~(wrFlags & pwdata[i]));
      end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        timerResult[i] <= 1'b0;
      end else if (!syncModeQ[i] || tmrFall) begin
        timerResult[i] <= resultQ[i];
      end
    end

    // pin follows the timer path; pin enable works whether or not the core is on
    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        resultPinOe[i] <= 1'b0;
      end else begin
        resultPinOe[i] <= pinEnQ[i] & ~resultPinDir[i];
      end
    end

    assign resultPinOut[i] = timerResult[i];
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // latch control registers

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      latchEnQ <= 1'(`CMPSR_LATCH_RST >> `CMPSR_L0_EN);
      divSelQ  <= 3'h0;
      qEnQ     <= 1'(`CMPSR_LATCH_RST >> `CMPSR_L0_QEN);
      qnEnQ    <= 1'(`CMPSR_LATCH_RST >> `CMPSR_L0_QNEN);
    end else if (wrLatch0) begin
      latchEnQ <= pwdata[`CMPSR_L0_EN];
      divSelQ  <= pwdata[`CMPSR_L0_DIV_HI:`CMPSR_L0_DIV_LO];
      qEnQ     <= pwdata[`CMPSR_L0_QEN];
      qnEnQ    <= pwdata[`CMPSR_L0_QNEN];
    end
  end

  // pulses last one cycle and drop by themselves
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      softSetQ <= 1'b0;
      softRstQ <= 1'b0;
    end else begin
      softSetQ <= wrLatch0 & pwdata[`CMPSR_L0_SSET];
      softRstQ <= wrLatch0 & pwdata[`CMPSR_L0_SRST];
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      srcEnQ <= `CMPSR_LATCH_RST;
    end else if (wrLatch1) begin
      srcEnQ <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // set/reset latch

  assign setIn = softSetQ
               | (srcEnQ[`CMPSR_L1_CLK_SET] & divPulse)
               | (srcEnQ[`CMPSR_L1_EXT_SET] & extS)
               | (srcEnQ[`CMPSR_L1_C2_SET]  & timerResult[1])
               | (srcEnQ[`CMPSR_L1_C1_SET]  & timerResult[0]);
  assign rstIn = softRstQ
               | (srcEnQ[`CMPSR_L1_CLK_RST] & divPulse)
               | (srcEnQ[`CMPSR_L1_EXT_RST] & extS)
               | (srcEnQ[`CMPSR_L1_C2_RST]  & timerResult[1])
               | (srcEnQ[`CMPSR_L1_C1_RST]  & timerResult[0]);

  // every input is already on this clock, so sampling each cycle loses no level
  assign latchNext = rstIn ? 1'b0 : (setIn ? 1'b1 : latchQOut);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      latchQOut  <= 1'b0;
      latchQnOut <= 1'b1;
    end else begin
      latchQOut  <= latchNext;
      latchQnOut <= ~latchNext;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      latchQOe  <= 1'b0;
      latchQnOe <= 1'b0;
    end else begin
      latchQOe  <= latchEnQ & qEnQ & ~latchQDir;
      latchQnOe <= latchEnQ & qnEnQ & ~latchQnDir;
    end
  end

endmodule // cmpsr_top

`default_nettype wire

// file: logic/cmpsr_consts.svh
// cmpsr_consts.svh: register offsets, field positions, reset values and divider constants
// for the comparator control and set/reset latch block.
// assumes a byte-addressed apb slave with one 32-bit word per register.
`ifndef CMPSR_CONSTS_SVH
`define CMPSR_CONSTS_SVH

// register byte offsets; comparator n (0..2) sits at base + n * stride
`define CMPSR_OFF_CTRL0_BASE 8'h00
`define CMPSR_OFF_CTRL1_BASE 8'h04
`define CMPSR_CH_STRIDE      8'h08
`define CMPSR_OFF_MIRROR     8'h18
`define CMPSR_OFF_LATCH0     8'h1C
`define CMPSR_OFF_LATCH1     8'h20
`define CMPSR_OFF_FLAGS      8'h24

// comparator_control_0 fields
`define CMPSR_C0_ON     7
`define CMPSR_C0_RESULT 6
`define CMPSR_C0_PINEN  5
`define CMPSR_C0_INV    4
`define CMPSR_C0_SPEED  2
`define CMPSR_C0_HYS    1
`define CMPSR_C0_SYNC   0

// comparator_control_1 fields
`define CMPSR_C1_RISE     7
`define CMPSR_C1_FALL     6
`define CMPSR_C1_PLUS_HI  5
`define CMPSR_C1_PLUS_LO  4
`define CMPSR_C1_MINUS_HI 1
`define CMPSR_C1_MINUS_LO 0

// latch_control_0 fields
`define CMPSR_L0_EN     7
`define CMPSR_L0_DIV_HI 6
`define CMPSR_L0_DIV_LO 4
`define CMPSR_L0_QEN    3
`define CMPSR_L0_QNEN   2
`define CMPSR_L0_SSET   1
`define CMPSR_L0_SRST   0

// latch_control_1 fields
`define CMPSR_L1_EXT_SET 7
`define CMPSR_L1_CLK_SET 6
`define CMPSR_L1_C2_SET  5
`define CMPSR_L1_C1_SET  4
`define CMPSR_L1_EXT_RST 3
`define CMPSR_L1_CLK_RST 2
`define CMPSR_L1_C2_RST  1
`define CMPSR_L1_C1_RST  0

// reset values
`define CMPSR_CTRL0_RST 8'h04
`define CMPSR_CTRL1_RST 8'h00
`define CMPSR_LATCH_RST 8'h00

// latch pulse clock: period is 4 << select, counter wide enough for 512
`define CMPSR_DIV_MIN_PERIOD 9'h004
`define CMPSR_DIV_CNT_W      9

`endif

// file: logic/cmpsr_pkg.sv
// cmpsr_pkg: types shared by the comparator control block.
// assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package cmpsr_pkg;
  typedef logic [7:0] cmpsr_byte_t;
  typedef logic [1:0] cmpsr_sel_t;
  // plus input routing codes
  typedef enum logic [1:0] {
    CMPSR_PLUS_PIN,
    CMPSR_PLUS_CONV_REF,
    CMPSR_PLUS_FIXED_REF,
    CMPSR_PLUS_GROUND
  } cmpsr_plus_t;
endpackage : cmpsr_pkg

`default_nettype wire

// file: logic/cmpsr_sync.sv
// cmpsr_sync: two flip-flop synchroniser for a group of asynchronous levels.
// assumes each bit is an independent level; no bus coherence is promised.
`default_nettype none

module cmpsr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,   // system clock
  input  wire logic             sys_rst, // async reset, active high
  input  wire logic [WIDTH-1:0] din,     // asynchronous levels
  output var  logic [WIDTH-1:0] dout     // synchronised levels
);
  logic [WIDTH-1:0] metaQ;

  // first stage is read only by the second stage
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      metaQ <= '0;
      dout  <= '0;
    end else begin
      metaQ <= din;
      dout  <= metaQ;
    end
  end
endmodule // cmpsr_sync

`default_nettype wire

// file: logic/cmpsr_pulse_div.sv
// cmpsr_pulse_div: free-running divider giving a one-cycle pulse every 4..512 cycles.
// assumes the select comes from a register on the same clock.
`default_nettype none
`include "cmpsr_consts.svh"

module cmpsr_pulse_div (
  input  wire logic       clock,   // system clock
  input  wire logic       sys_rst, // async reset, active high
  input  wire logic [2:0] sel,     // period select, 000 = 4 ... 111 = 512
  output var  logic       pulse    // one-cycle pulse
);
  logic [`CMPSR_DIV_CNT_W-1:0] cntQ;
  logic [`CMPSR_DIV_CNT_W-1:0] mask;

  // low bits of a free counter wrap once per period; a select change may shorten one period
  assign mask = `CMPSR_DIV_CNT_W'((`CMPSR_DIV_MIN_PERIOD << sel) - 9'h001);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cntQ <= '0;
    end else begin
      cntQ <= `CMPSR_DIV_CNT_W'(cntQ + 9'h001);
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pulse <= 1'b0;
    end else begin
      pulse <= ((cntQ & mask) == mask);
    end
  end
endmodule // cmpsr_pulse_div

`default_nettype wire

// file: tb/cmpsr_sva.sv
// cmpsr_sva: port-level checks on cmpsr_top.
// assumes a bind from the bench top file; apb writes land at the access edge.
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module cmpsr_sva (
  input wire logic        clock,        // system clock
  input wire logic        sys_rst,      // async reset
  input wire logic        psel,         // apb select
  input wire logic        penable,      // apb access
  input wire logic        pwrite,       // apb direction
  input wire logic [31:0] prdata,       // apb read data
  input wire logic        pready,       // apb ready
  input wire logic [2:0]  cmpOn,        // power enables
  input wire logic [2:0]  cmpFast,      // speed selects
  input wire logic [5:0]  plusSel,      // plus selects
  input wire logic [5:0]  minusSel,     // minus selects
  input wire logic [2:0]  timerResult,  // timer results
  input wire logic [2:0]  resultPinDir, // pin directions
  input wire logic [2:0]  resultPinOut, // pin values
  input wire logic [2:0]  resultPinOe,  // pin enables
  input wire logic        latchQDir,    // q pin direction
  input wire logic        latchQOut,    // latch q
  input wire logic        latchQOe,     // q pin enable
  input wire logic        latchQnOut    // latch q bar
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // configuration outputs may only move one edge after a write access
  on_cfg_a: assert property ($changed(cmpOn) |-> $past(psel && penable && pwrite))
    else $error("power enable moved without a write");
  speed_cfg_a: assert property ($changed(cmpFast) |-> $past(psel && penable && pwrite))
    else $error("speed select moved without a write");
  plus_cfg_a: assert property ($changed(plusSel) |-> $past(psel && penable && pwrite))
    else $error("plus select moved without a write");
  minus_cfg_a: assert property ($changed(minusSel) |-> $past(psel && penable && pwrite))
    else $error("minus select moved without a write");
  pin_value_a: assert property (resultPinOut == timerResult)
    else $error("pin value differs from timer result");
  pin_dir_a: assert property ((resultPinOe & $past(resultPinDir)) == 3'h0)
    else $error("result pin driven while direction is input");
  q_dir_a: assert property (latchQOe |-> !$past(latchQDir))
    else $error("q pin driven while direction is input");
  q_compl_a: assert property (latchQnOut == !latchQOut)
    else $error("latch outputs not complementary");
  rd_upper_a: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
endmodule // cmpsr_sva
`default_nettype wire

// file: tb/cmpsr_analog.sv
// cmpsr_analog: behavioural analog cores, reference levels and gate timer clock.
// assumes the bench sets each plus pin high or low and starts or stops the timer.
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module cmpsr_analog (
  input  wire logic [2:0] cmpOn,        // power enables
  input  wire logic [5:0] plusSel,      // plus selects
  input  wire logic [5:0] minusSel,     // minus selects
  input  wire logic [2:0] plusHigh,     // plus pin level, 1 = 2.0 V
  input  wire logic       tmrRun,       // timer clock runs
  output var  logic [2:0] cmpRaw,       // raw results
  output var  logic       gateTimerClk  // timer clock source
);
  timeunit 1ns;
  timeprecision 1ps;
  function automatic logic res(logic on, logic [1:0] ps, logic [1:0] ns, logic hi);
    real vp;
    real vn;
    case (ps)
      2'h0: vp = hi ? 2.0 : 0.1;
      2'h1: vp = 1.5;
      2'h2: vp = 1.0;
      default: vp = 0.0;
    endcase
    vn = 0.25 + 0.5 * ns;
    // an unpowered core gives no valid answer; low is its resting output
    return on && (vp > vn);
  endfunction
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      cmpRaw[i] = res(cmpOn[i], plusSel[2*i+:2], minusSel[2*i+:2], plusHigh[i]);
    end
  end
  // stands low while stopped, so no stray falling edge
  initial gateTimerClk = 1'b0;
  always #7 gateTimerClk = tmrRun ? ~gateTimerClk : 1'b0;
endmodule // cmpsr_analog
`default_nettype wire

// file: tb/tb_comparator_control_sr_latch.sv
// tb_comparator_control_sr_latch: apb sequences with expected values for cmpsr_top.
// assumes cmpsr_analog on the comparator side; bench drives pins and bus.
`default_nettype none
`include "cmpsr_consts.svh"
////////////////////////////////////////////////////////////////////////////////
module tb_comparator_control_sr_latch;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, sys_rst, psel, penable, pwrite, gateTimerClk, tmrRun;
  logic        latchExtPin, latchQDir, latchQnDir, pready, pslverr;
  logic        latchQOut, latchQOe, latchQnOut, latchQnOe;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0]  cmpRaw, cmpOn, cmpFast, cmpHyst, timerResult, plusHigh;
  logic [2:0]  resultPinDir, resultPinOut, resultPinOe;
  logic [5:0]  plusSel, minusSel;
  int          mismatches, nCompared, cycles, c;
  cmpsr_top uut (.clock, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb(4'hF),
    .prdata, .pready, .pslverr, .cmpRaw, .cmpOn, .cmpFast, .cmpHyst, .plusSel, .minusSel,
    .gateTimerClk, .timerResult, .resultPinDir, .resultPinOut, .resultPinOe, .latchExtPin,
    .latchQDir, .latchQnDir, .latchQOut, .latchQOe, .latchQnOut, .latchQnOe);
  cmpsr_analog ana (.cmpOn, .plusSel, .minusSel, .plusHigh, .tmrRun, .cmpRaw, .gateTimerClk);
  always #2.5 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    nCompared++;
    if (g !== x) begin
      mismatches++;
      $display("ERROR t=%0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h000000, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b1, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic xe = 1'b0);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b0, 8'h00, r, e);
    chk(r, {24'h000000, x});
    chk(32'(e), 32'(xe));
  endtask
  // ends mid-cycle so port values are looked at once settled
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  // cycles from one low sample of q to the next
  task automatic gap(output int n);
    n = 0;
    do begin @(posedge clock); n++; end while (latchQOut !== 1'b1);
    do begin @(posedge clock); n++; end while (latchQOut !== 1'b0);
  endtask
  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {clock, psel, penable, pwrite, tmrRun, latchExtPin, latchQDir, latchQnDir} = 8'h00;
    {paddr, pwdata, plusHigh, resultPinDir} = 46'h0;
    {mismatches, nCompared, cycles} = '0;
    sys_rst = 1'b1;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    for (int n = 0; n < 3; n++) begin
      rd(8'(8 * n), `CMPSR_CTRL0_RST);
      rd(8'(8 * n + 4), 8'h00);
    end
    rd(`CMPSR_OFF_MIRROR, 8'h00);
    rd(8'h3C, 8'h00, 1'b1);
    chk(32'(cmpFast), 32'h7);
    $display("test reset done");
    wr(8'h08, 8'hFE);
    wait_n(6);
    rd(8'h08, 8'hF6);
    rd(`CMPSR_OFF_MIRROR, 8'h02);
    chk(32'({resultPinOe, resultPinOut}), 32'h12);
    chk(32'({cmpOn, cmpFast, cmpHyst}), 32'h0BA);
    wr(8'h08, 8'h20);
    wait_n(6);
    rd(8'h08, 8'h20);
    chk(32'({cmpOn, cmpFast, cmpHyst}), 32'h028);
    chk(32'(resultPinOe), 32'h2);
    resultPinDir <= 3'b010;
    wait_n(3);
    chk(32'(resultPinOe), 32'h0);
    wr(8'h0C, 8'hFF);
    rd(8'h0C, 8'hF3);
    wr(8'h14, 8'h32);
    wait_n(1);
    chk(32'({plusSel[5:4], minusSel[5:4]}), 32'hE);
    $display("test config done");
    wr(8'h00, 8'h84);
    plusHigh <= 3'b001;
    for (int p = 0; p < 4; p++) begin
      for (int n = 0; n < 4; n++) begin
        wr(8'h04, 8'(p * 16 + n));
        wait_n(6);
        chk(32'({plusSel[1:0], minusSel[1:0]}), 32'(p * 4 + n));
        rd(8'h00, (p == 0 || (p == 1 && n < 3) || (p == 2 && n < 2)) ? 8'hC4 : 8'h84);
      end
    end
    $display("test routing done");
    plusHigh <= 3'b000;
    for (int k = 0; k < 4; k++) begin
      wr(8'h04, (k < 2) ? 8'h80 : 8'h40);
      wr(`CMPSR_OFF_FLAGS, 8'h07);
      plusHigh[0] <= ~k[0];
      wait_n(8);
      rd(`CMPSR_OFF_FLAGS, 8'((k == 0) || (k == 3)));
    end
    $display("test edges done");
    wr(8'h14, 8'h00);
    wr(8'h10, 8'h85);
    plusHigh <= 3'b100;
    wait_n(8);
    chk(32'(timerResult[2]), 32'h0);
    rd(`CMPSR_OFF_MIRROR, 8'h04);
    tmrRun <= 1'b1;
    wait_n(20);
    chk(32'(timerResult[2]), 32'h1);
    tmrRun <= 1'b0;
    wait_n(10);
    plusHigh <= 3'b000;
    wait_n(10);
    rd(8'h10, 8'h85);
    chk(32'(timerResult[2]), 32'h1);
    $display("test sync done");
    wr(`CMPSR_OFF_LATCH0, 8'h8E);
    wait_n(4);
    chk(32'({latchQOut, latchQnOut, latchQOe, latchQnOe}), 32'hB);
    rd(`CMPSR_OFF_LATCH0, 8'h8C);
    wr(`CMPSR_OFF_LATCH0, 8'h8F);
    wait_n(4);
    chk(32'(latchQOut), 32'h0);
    wr(`CMPSR_OFF_LATCH1, 8'h80);
    latchExtPin <= 1'b1;
    wait_n(6);
    chk(32'(latchQOut), 32'h1);
    wr(`CMPSR_OFF_LATCH1, 8'h88);
    wait_n(4);
    chk(32'(latchQOut), 32'h0);
    latchExtPin <= 1'b0;
    latchQDir <= 1'b1;
    wait_n(2);
    chk(32'(latchQOe), 32'h0);
    $display("test latch done");
    plusHigh <= 3'b001;
    wr(`CMPSR_OFF_LATCH1, 8'h14);
    for (int s = 0; s < 8; s++) begin
      wr(`CMPSR_OFF_LATCH0, {1'b1, 3'(s), 4'hC});
      gap(c);
      gap(c);
      gap(c);
      chk(32'(c), 32'(4 << s));
    end
    $display("test divider done");
    report_and_stop();
  end
endmodule // tb_comparator_control_sr_latch
bind cmpsr_top cmpsr_sva chk_i (.clock, .sys_rst, .psel, .penable, .pwrite, .prdata, .pready,
  .cmpOn, .cmpFast, .plusSel, .minusSel, .timerResult, .resultPinDir, .resultPinOut,
  .resultPinOe, .latchQDir, .latchQOut, .latchQOe, .latchQnOut);
`default_nettype wire
